// >>> pkg/serial_regs_pkg.sv
package serial_regs_pkg;

    localparam int ADDR_W = 16;

    // Register byte addresses
    localparam logic [15:0] OWN_ADDR_OFS = 16'h3004;
    localparam logic [15:0] CTRL_OFS = 16'h3008;
    localparam logic [15:0] STATUS_OFS = 16'h300C;
    localparam logic [15:0] DATA_OFS = 16'h3010;
    localparam logic [15:0] EVT_OFS = 16'h3014;
    localparam logic [15:0] MASK_OFS = 16'h3018;

    // serial_status fields
    localparam int ST_DONE = 7;
    localparam int ST_HIT = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_ARB = 4;
    localparam int ST_DIR = 2;
    localparam int ST_PEND = 1;
    localparam int ST_ACK = 0;

    // serial_control fields
    localparam int CT_EN = 7;
    localparam int CT_IEN = 6;
    localparam int CT_MST = 5;
    localparam int CT_TX = 4;
    localparam int CT_NOACK = 3;

    // Event status and mask fields
    localparam int EV_W = 5;
    localparam int EV_DONE = 0;
    localparam int EV_HIT = 1;
    localparam int EV_ARB = 2;
    localparam int EV_START = 3;
    localparam int EV_STOP = 4;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;

    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_OWN = 3'h1,
        REG_CTRL = 3'h2,
        REG_STATUS = 3'h3,
        REG_DATA = 3'h4,
        REG_EVT = 3'h5,
        REG_MASK = 3'h6
    } reg_sel_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_WAIT = 2'b11,
        LINK_PASSIVE = 2'b10
    } link_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage : serial_regs_pkg

// >>> rtl/serial_status_data.sv
`timescale 1ns/1ps
module serial_status_data
    import serial_regs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire apb_req_t i_apb,
    output apb_rsp_t o_apb,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_irq
);

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        link_state_t link;
        logic skip;
        logic [3:0] bitcnt;
        logic first;
        logic armed;
        logic addressed;
        logic [7:0] shift;
        logic [7:0] data;
        logic [6:0] own_addr;
        logic en;
        logic ien;
        logic mst;
        logic txsel;
        logic noack;
        logic done;
        logic hit;
        logic busy;
        logic arb;
        logic dir;
        logic pend;
        logic ack;
        logic [EV_W-1:0] evt;
        logic [EV_W-1:0] mask;
        logic sda_oe;
        logic scl_oe;
        logic irq;
        apb_rsp_t rsp;
    } state_t;

    state_t q;
    state_t d;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        unique case (addr)
            OWN_ADDR_OFS: decode = REG_OWN;
            CTRL_OFS: decode = REG_CTRL;
            STATUS_OFS: decode = REG_STATUS;
            DATA_OFS: decode = REG_DATA;
            EVT_OFS: decode = REG_EVT;
            MASK_OFS: decode = REG_MASK;
            default: decode = REG_NONE;
        endcase
    endfunction : decode

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic apb_setup;
    logic apb_wr;
    logic apb_rd;
    reg_sel_t sel_now;
    logic [3:0] tx_idx;
    logic tx_bit;
    logic tx_mode;
    logic fall9;
    logic fall8;
    logic hit_ev;
    logic arb_ev;
    logic data_go;
    logic ctrl_wr;
    logic [31:0] rd_word;

    // Edges only from the second sync stage onward
    assign scl_rise = q.scl_s2 & ~q.scl_p;
    assign scl_fall = ~q.scl_s2 & q.scl_p;
    assign start_ev = q.en & q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    assign stop_ev = q.en & q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
    assign apb_setup = i_apb.psel & ~i_apb.penable;
    assign apb_wr = i_apb.psel & i_apb.penable & q.rsp.pready & i_apb.pwrite;
    assign apb_rd = i_apb.psel & i_apb.penable & q.rsp.pready & ~i_apb.pwrite;
    assign sel_now = decode(i_apb.paddr);
    assign ctrl_wr = apb_wr & (sel_now == REG_CTRL);
    assign tx_idx = BIT_LAST_DATA - q.bitcnt;
    assign tx_bit = q.data[tx_idx[2:0]];
    // Address byte always goes out in master mode
    assign tx_mode = q.first ? q.mst : q.txsel;
    assign fall9 = q.en & (q.link == LINK_SHIFT) & scl_fall & ~q.skip & (q.bitcnt == BIT_ACK);
    assign fall8 = q.en & (q.link == LINK_SHIFT) & scl_fall & ~q.skip
        & (q.bitcnt == BIT_LAST_DATA);
    assign hit_ev = fall8 & q.first & ~q.mst & (q.shift[7:1] == q.own_addr);
    // Lost when a released one reads back low
    assign arb_ev = q.en & (q.link == LINK_SHIFT) & scl_rise & ~q.skip & q.mst & tx_mode
        & (q.bitcnt < BIT_ACK) & tx_bit & ~q.sda_s2;
    assign data_go = (sel_now == REG_DATA) & ((apb_wr & q.txsel) | (apb_rd & ~q.txsel));

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (sel_now)
            REG_OWN: rd_word[7:1] = q.own_addr;
            REG_CTRL: rd_word[7:3] = {q.en, q.ien, q.mst, q.txsel, q.noack};
            REG_STATUS: rd_word[7:0] = {q.done, q.hit, q.busy, q.arb, 1'b0, q.dir, q.pend, q.ack};
            REG_DATA: rd_word[7:0] = q.data;
            REG_EVT: rd_word[EV_W-1:0] = q.evt;
            REG_MASK: rd_word[EV_W-1:0] = q.mask;
            REG_NONE: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        d.scl_s1 = i_scl;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = i_sda;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;

        // Zero-wait APB: read data sampled in setup, answer in first access cycle
        d.rsp.pready = apb_setup;
        d.rsp.pslverr = apb_setup & (sel_now == REG_NONE);
        d.rsp.prdata = (apb_setup & ~i_apb.pwrite) ? rd_word : 32'h0000_0000;

        // Software side first so that hardware sets below win
        if (apb_wr) begin
            unique case (sel_now)
                REG_OWN: d.own_addr = i_apb.pwdata[7:1];
                REG_CTRL: begin
                    d.en = i_apb.pwdata[CT_EN];
                    d.ien = i_apb.pwdata[CT_IEN];
                    d.mst = i_apb.pwdata[CT_MST];
                    d.txsel = i_apb.pwdata[CT_TX];
                    d.noack = i_apb.pwdata[CT_NOACK];
                end
                // Only arb-lost and pending clear, by writing zero
                REG_STATUS: begin
                    if (!i_apb.pwdata[ST_ARB]) begin
                        d.arb = 1'b0;
                    end
                    if (!i_apb.pwdata[ST_PEND]) begin
                        d.pend = 1'b0;
                    end
                end
                REG_DATA: d.data = i_apb.pwdata[7:0];
                REG_EVT: d.evt = q.evt & ~i_apb.pwdata[EV_W-1:0];
                REG_MASK: d.mask = i_apb.pwdata[EV_W-1:0];
                REG_NONE: d.mask = q.mask;
            endcase
        end
        if (ctrl_wr) begin
            d.hit = 1'b0;
        end
        if (data_go) begin
            d.done = 1'b0;
            d.armed = 1'b1;
        end

        if (!q.en) begin
            // Held in reset while disabled; registers stay reachable
            d.link = LINK_IDLE;
            d.skip = 1'b0;
            d.bitcnt = 4'h0;
            d.addressed = 1'b0;
        end else if (start_ev) begin
            d.busy = 1'b1;
            d.evt[EV_START] = 1'b1;
            d.link = LINK_SHIFT;
            d.skip = 1'b1;
            d.bitcnt = 4'h0;
            d.first = 1'b1;
            d.addressed = 1'b0;
            d.done = 1'b0;
        end else if (stop_ev) begin
            d.busy = 1'b0;
            d.evt[EV_STOP] = 1'b1;
            d.link = LINK_IDLE;
            d.addressed = 1'b0;
        end else begin
            unique case (q.link)
                LINK_SHIFT: begin
                    if (scl_rise && !q.skip) begin
                        if (q.bitcnt < BIT_ACK) begin
                            d.shift = {q.shift[6:0], q.sda_s2};
                        end else begin
                            d.ack = q.sda_s2;
                        end
                    end
                    if (arb_ev) begin
                        d.arb = 1'b1;
                        d.pend = 1'b1;
                        d.mst = 1'b0;
                        d.txsel = 1'b0;
                        d.evt[EV_ARB] = 1'b1;
                        d.link = LINK_PASSIVE;
                    end else if (scl_fall) begin
                        if (q.skip) begin
                            d.skip = 1'b0;
                        end else if (q.bitcnt == BIT_ACK) begin
                            d.bitcnt = 4'h0;
                            d.done = 1'b1;
                            d.pend = 1'b1;
                            d.evt[EV_DONE] = 1'b1;
                            d.first = 1'b0;
                            d.armed = 1'b0;
                            d.link = LINK_WAIT;
                        end else begin
                            d.bitcnt = q.bitcnt + 4'h1;
                            if (fall8 && q.first && !q.mst) begin
                                if (hit_ev) begin
                                    d.hit = 1'b1;
                                    d.pend = 1'b1;
                                    d.evt[EV_HIT] = 1'b1;
                                    d.addressed = 1'b1;
                                    d.dir = q.shift[0];
                                end else begin
                                    d.link = LINK_PASSIVE;
                                end
                            end else if (fall8 && !tx_mode) begin
                                d.data = q.shift;
                            end
                        end
                    end
                end
                // Stretch until software services the data register
                LINK_WAIT: begin
                    if (q.armed && (q.mst || q.addressed)) begin
                        d.link = LINK_SHIFT;
                        d.skip = 1'b0;
                    end else if (!q.mst && !q.addressed) begin
                        d.link = LINK_PASSIVE;
                    end
                end
                LINK_IDLE: d.link = LINK_IDLE;
                LINK_PASSIVE: d.link = LINK_PASSIVE;
            endcase
        end

        // MSB first; acks only as receiver
        d.sda_oe = q.en & (q.link == LINK_SHIFT) & ~q.skip & ~arb_ev & (
            ((q.bitcnt < BIT_ACK) & tx_mode & ~tx_bit)
            | ((q.bitcnt == BIT_ACK) & ~tx_mode
               & ((q.first & q.addressed) | (~q.first & ~q.noack))));
        d.scl_oe = q.en & (q.link == LINK_WAIT) & ~q.armed & (q.mst | q.addressed);
        d.irq = (d.ien & d.pend) | (|(d.evt & d.mask));

        // Done, ack and the sync stages set, all else clear
        if (i_srst) begin
            d = '0;
            d.scl_s1 = 1'b1;
            d.scl_s2 = 1'b1;
            d.scl_p = 1'b1;
            d.sda_s1 = 1'b1;
            d.sda_s2 = 1'b1;
            d.sda_p = 1'b1;
            d.data = DATA_RST;
            d.done = 1'b1;
            d.ack = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        q <= d;
    end

    assign o_apb = q.rsp;
    assign o_sda_oe = q.sda_oe;
    assign o_scl_oe = q.scl_oe;
    assign o_sda_o = 1'b0;
    assign o_scl_o = 1'b0;
    assign o_irq = q.irq;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    done_set_a: assert property (fall9 |=> q.done)
        else $error("byte done not set at ninth falling edge");
    done_clr_a: assert property (data_go && !fall9 |=> !q.done)
        else $error("byte done not cleared by data access");
    hit_set_a: assert property (hit_ev |=> q.hit && q.pend && q.addressed)
        else $error("address match not flagged");
    hit_clr_a: assert property (ctrl_wr && !hit_ev |=> !q.hit)
        else $error("control write did not clear match");
    busy_a: assert property (start_ev |=> q.busy)
        else $error("busy flag not set by START");
    busy_stop_a: assert property (stop_ev |=> !q.busy)
        else $error("busy flag not cleared by STOP");
    arb_a: assert property (arb_ev |=> q.arb && !q.mst && !q.txsel && q.link == LINK_PASSIVE)
        else $error("arbitration loss handling wrong");
    keep_a: assert property (q.arb && !(apb_wr && sel_now == REG_STATUS) |=> q.arb)
        else $error("arb lost cleared by hardware");
    dir_a: assert property (hit_ev |=> q.dir == $past(q.shift[0]))
        else $error("slave direction not captured");
    irq_a: assert property (q.pend && q.ien |=> ##1 o_irq || !q.pend || !q.ien)
        else $error("interrupt missing while pending and enabled");
    rsv_a: assert property (apb_setup && !i_apb.pwrite && sel_now == REG_STATUS
        |=> o_apb.prdata[31:8] == 24'h000000 && !o_apb.prdata[3])
        else $error("reserved status bits not zero");
    msb_a: assert property (q.en && q.link == LINK_SHIFT && !q.skip && tx_mode && q.bitcnt == 4'h0
        && !arb_ev && $stable(q.link) |=> o_sda_oe == !$past(q.data[7]))
        else $error("first bit is not the msb");

    done_c: cover property (fall9 ##[1:1000] data_go);
    hit_c: cover property (hit_ev);
    arb_c: cover property (arb_ev);
    irq_c: cover property ($rose(o_irq));

endmodule : serial_status_data

// >>> dv/link_master_model.sv
`timescale 1ns/1ps
module link_master_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_pull,
    output logic o_sda_pull
);
    logic tick;
    logic [7:0] rx_byte;
    logic ack_seen;

    initial begin
        o_scl_pull = 1'b0;
        o_sda_pull = 1'b0;
        tick = 1'b0;
        // Odd-ns edges never meet the 8 ns clock edges
        #3;
        forever begin
            tick = ~tick;
            #5;
        end
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge tick);
    endtask : ticks

    // Data falls while clock high
    task automatic start_cond;
        ticks(1);
        o_sda_pull = 1'b1;
        ticks(4);
        o_scl_pull = 1'b1;
        ticks(2);
    endtask : start_cond

    // Data rises while clock high; honours a stretch first
    task automatic stop_cond;
        ticks(1);
        o_sda_pull = 1'b1;
        ticks(2);
        o_scl_pull = 1'b0;
        wait (i_scl);
        ticks(4);
        o_sda_pull = 1'b0;
        ticks(4);
    endtask : stop_cond

    task automatic clk_bit(input logic b, output logic s);
        o_scl_pull = 1'b1;
        ticks(2);
        o_sda_pull = ~b;
        ticks(2);
        o_scl_pull = 1'b0;
        wait (i_scl);
        ticks(2);
        s = i_sda;
        ticks(2);
    endtask : clk_bit

    // Eight bits MSB first, then the acknowledge slot, clock left low
    task automatic xfer(input logic [7:0] tx, input logic ack_in);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s);
            rx_byte[i] = s;
        end
        clk_bit(ack_in, ack_seen);
        o_scl_pull = 1'b1;
        ticks(2);
        o_sda_pull = 1'b0;
    endtask : xfer
endmodule : link_master_model

// >>> dv/i2c_status_and_data_regs_test.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module i2c_status_and_data_regs_test
    import serial_regs_pkg::*;
;
    logic ref_clk;
    logic srst;
    apb_req_t req;
    apb_rsp_t rsp;
    logic scl_oe;
    logic sda_oe;
    logic irq;
    logic m_scl;
    logic m_sda;
    wire logic scl_w;
    wire logic sda_w;
    logic [31:0] rd;
    logic err;
    int checked;
    int n_mismatch;

    serial_status_data dut (
        .i_ref_clk(ref_clk),
        .i_srst(srst),
        .i_apb(req),
        .o_apb(rsp),
        .i_scl(scl_w),
        .o_scl_o(),
        .o_scl_oe(scl_oe),
        .i_sda(sda_w),
        .o_sda_o(),
        .o_sda_oe(sda_oe),
        .o_irq(irq)
    );

    link_master_model far (
        .i_scl(scl_w),
        .i_sda(sda_w),
        .o_scl_pull(m_scl),
        .o_sda_pull(m_sda)
    );

    // Open-drain wires with pull-ups
    assign scl_w = ~(scl_oe | m_scl);
    assign sda_w = ~(sda_oe | m_sda);

    always #4 ref_clk = ~ref_clk;

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n == 20) begin
            n_mismatch++;
            $display("MISMATCH pready expected 1 seen %0h", rsp.pready);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rdchk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd & m)
    endtask : rdchk

    // Flag updates trail the wire by a few clocks
    task automatic settle;
        repeat (8) @(posedge ref_clk);
    endtask : settle

    task automatic t_reset;
        rdchk(STATUS_OFS, 32'hFFFFFFFF, 32'h81); // status reset
        apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
        rdchk(STATUS_OFS, 32'hFFFFFFFF, 32'h81); // no set
        apb(1'b0, 16'h3020, 32'h0);
        `CHK("unmapped err", 1'b1, err) // refused
        rdchk(DATA_OFS, 32'hFFFFFFFF, 32'h0); // data reset
        rdchk(STATUS_OFS, 32'h80, 32'h0); // read clears done
        $display("test reset done");
    endtask : t_reset

    task automatic t_slave_tx;
        apb(1'b1, OWN_ADDR_OFS, 32'hAA);
        apb(1'b1, MASK_OFS, 32'h08);
        apb(1'b1, CTRL_OFS, 32'hC0);
        far.start_cond();
        settle();
        `CHK("start irq", 1'b1, irq) // start seen
        rdchk(EVT_OFS, 32'h1F, 32'h08); // start event
        apb(1'b1, EVT_OFS, 32'h08);
        rdchk(STATUS_OFS, 32'hFF, 32'h21); // busy set
        `CHK("irq cleared", 1'b0, irq) // nothing pending
        far.xfer(8'hAB, 1'b1);
        settle();
        `CHK("addr ack", 1'b0, far.ack_seen) // address acked
        `CHK("addr irq", 1'b1, irq) // irq raised
        `CHK("stretch", 1'b1, scl_oe) // clock held low
        rdchk(STATUS_OFS, 32'hFF, 32'hE6); // flags
        apb(1'b1, CTRL_OFS, 32'h90);
        rdchk(STATUS_OFS, 32'hFB, 32'hA2); // hit cleared
        `CHK("irq off", 1'b0, irq) // masked by enable
        apb(1'b1, STATUS_OFS, 32'h0);
        rdchk(STATUS_OFS, 32'h02, 32'h0); // pending cleared
        apb(1'b1, DATA_OFS, 32'hA5);
        rdchk(STATUS_OFS, 32'h80, 32'h0); // write clears done
        `CHK("released", 1'b0, scl_oe) // write releases clock
        far.xfer(8'hFF, 1'b1);
        settle();
        `CHK("tx byte", 8'hA5, far.rx_byte) // msb first
        rdchk(STATUS_OFS, 32'hFB, 32'hA3); // no ack seen
        apb(1'b1, CTRL_OFS, 32'h80);
        apb(1'b0, DATA_OFS, 32'h0);
        far.stop_cond();
        settle();
        rdchk(STATUS_OFS, 32'h20, 32'h0); // idle after stop
        $display("test slave_tx done");
    endtask : t_slave_tx

    task automatic t_slave_rx;
        apb(1'b1, STATUS_OFS, 32'h0);
        far.start_cond();
        far.xfer(8'h70, 1'b1);
        settle();
        `CHK("foreign ack", 1'b1, far.ack_seen) // stays passive
        rdchk(STATUS_OFS, 32'h40, 32'h0); // no hit
        far.stop_cond();
        far.start_cond();
        far.xfer(8'hAA, 1'b1);
        settle();
        rdchk(STATUS_OFS, 32'h46, 32'h42); // receive hit
        apb(1'b1, CTRL_OFS, 32'h80);
        apb(1'b0, DATA_OFS, 32'h0);
        far.xfer(8'h3C, 1'b1);
        settle();
        `CHK("data ack", 1'b0, far.ack_seen) // byte acked
        apb(1'b0, DATA_OFS, 32'h0);
        `CHK("rx byte", 32'h3C, rd) // byte returned
        rdchk(STATUS_OFS, 32'h80, 32'h0); // read clears done
        far.stop_cond();
        $display("test slave_rx done");
    endtask : t_slave_rx

    task automatic final_report;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Whole run needs well under a tenth of this
    initial begin
        #200000;
        n_mismatch++;
        $display("MISMATCH watchdog expected done seen timeout");
        final_report();
    end

    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        req = '0;
        checked = 0;
        n_mismatch = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_slave_tx();
        t_slave_rx();
        final_report();
    end
endmodule : i2c_status_and_data_regs_test
